// *** logic/edou_params.svh ***
// register offsets, crossing codes, reset values and sizes for the event driven output block
// Overview of operation
// - crossing enable bit one loads that output on zero-crossing events
// - crossing enable bit zero: crossing events never change that output
// - alert enable bit one loads output when a selected alert flag sets
// - alert enable bit zero: alert flags ignored, output keeps its level
// - per-output source mask picks which channels' alerts can load it
// - alert load drives the output to its alert value bit, zero low one high
// - alert value bit acts only while that output's alert enable is set
// - each pin is digital input, open-drain output or push-pull output
// - input pins' levels readable by software in the input state register
// - open-drain output not asserted releases the line to the pull-up
// - asserted open-drain output pulls the line low
// - push-pull output always drives the line high or low, never floats
// - two-bit code per channel sets levels on rising and falling crossings
`ifndef EDOU_PARAMS_SVH
`define EDOU_PARAMS_SVH
`define EDOU_NCH              8
`define EDOU_AW               8
// register offsets are word indices: byte address = 4 * index
`define EDOU_IDX_EDGE_LO      8'he3
`define EDOU_IDX_EDGE_HI      8'he4
`define EDOU_IDX_XING_EN      8'he7
`define EDOU_IDX_ALERT_EN     8'he9
`define EDOU_IDX_ALERT_VAL    8'heb
`define EDOU_IDX_SRC_BASE     8'hc0
`define EDOU_IDX_PIN_FUNC     8'h10
`define EDOU_IDX_DRIVE        8'h11
`define EDOU_IDX_SW_VAL       8'h12
`define EDOU_IDX_IN_STATE     8'h13
`define EDOU_IDX_OUT_STATE    8'h14
`define EDOU_RST_BYTE         8'h00
`define EDOU_CODE_LOW         2'h0
`define EDOU_CODE_INV         2'h1
`define EDOU_CODE_FOLLOW      2'h2
`define EDOU_CODE_HIGH        2'h3
`endif

// *** logic/edou_pkg.sv ***
// types shared by the event driven output block
package edou_pkg;
    typedef logic [7:0] edou_byte_t;
    typedef enum logic [1:0] {
        EDOU_PIN_INPUT,
        EDOU_PIN_OPEN_DRAIN,
        EDOU_PIN_PUSH_PULL
    } edou_pin_e;
    typedef enum {
        EDOU_BUS_IDLE,
        EDOU_BUS_ANSWER
    } edou_bus_e;
endpackage

// *** logic/edou_pin_if.sv ***
// interface carrying output level and pin mode between the core and the pin driver
`timescale 1ns/100ps
interface edou_pin_if;
    logic [7:0]           level;
    logic [7:0]           is_output;
    logic [7:0]           is_push_pull;
    modport core (output level, output is_output, output is_push_pull);
    modport pad  (input level, input is_output, input is_push_pull);
endinterface

// *** logic/edou_pad.sv ***
// pin driver turning output levels and pin modes into pad signals
`timescale 1ns/100ps
module edou_pad (
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    edou_pin_if.pad         pin,
    output logic      [7:0] o_pad_out,
    output logic      [7:0] o_pad_oe_n
);
    logic [7:0] next_oe_n;
    logic [7:0] next_out;

    // open drain only ever drives zero; push-pull drives both levels
    assign next_out  = pin.level & pin.is_push_pull;
    assign next_oe_n = ~(pin.is_output & (pin.is_push_pull | ~pin.level));

    // registered pad drive, all released during reset
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pad_out  <= 8'h00;
            o_pad_oe_n <= 8'hff;
        end else begin
            o_pad_out  <= next_out;
            o_pad_oe_n <= next_oe_n;
        end
    end

    // push-pull pin is driven one cycle after its mode settles
    push_pull_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (pin.is_output[0] && pin.is_push_pull[0]) |=> !o_pad_oe_n[0])
        else $error("push-pull pin not driven");
    open_drain_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (pin.is_output[0] && !pin.is_push_pull[0] && pin.level[0]) |=> o_pad_oe_n[0])
        else $error("open-drain high not released");
    od_low_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !o_pad_oe_n[1] && !pin.is_push_pull[1] |-> !o_pad_out[1] || $past(pin.is_push_pull[1]))
        else $error("open-drain drives high");
endmodule

// *** logic/edou_top.sv ***
// event driven output update block with avalon-mm register slave
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "edou_params.svh"
module edou_top (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic [9:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    output logic      [1:0]  o_avs_response,
    input  wire logic [7:0]  i_xing,
    input  wire logic [7:0]  i_alert_flags,
    input  wire logic [7:0]  i_pad_in,
    output logic      [7:0]  o_pad_out,
    output logic      [7:0]  o_pad_oe_n
);
    // configuration registers
    logic [7:0]  edge_code_lo;
    logic [7:0]  edge_code_hi;
    logic [7:0]  xing_en;
    logic [7:0]  alert_en;
    logic [7:0]  alert_val;
    logic [7:0]  src_sel [8];
    logic [7:0]  pin_func;
    logic [7:0]  drive_pp;
    logic [7:0]  sw_val;
    logic [7:0]  out_level;
    logic [7:0]  in_state;
    edou_pkg::edou_bus_e bus_state;

    // pad and event synchronisers: first stage read by second stage only
    logic [7:0]  pad_s1;
    logic [7:0]  pad_s2;
    logic [7:0]  xing_s1;
    logic [7:0]  xing_s2;
    logic [7:0]  xing_d;
    logic [7:0]  alert_s1;
    logic [7:0]  alert_s2;
    logic [7:0]  alert_d;

    edou_pin_if pin_bus ();

    // bus decode: byte address is four times the register index
    // a write lands only at the edge where the master sees waitrequest low
    wire  [7:0]  idx      = i_avs_address[9:2];
    wire         aligned  = (i_avs_address[1:0] == 2'h0);
    wire         req      = i_avs_read | i_avs_write;
    wire         wr_low   = (bus_state == edou_pkg::EDOU_BUS_ANSWER) & i_avs_write & i_avs_byteenable[0] & aligned;
    wire         src_hit  = (idx[7:3] == 5'(`EDOU_IDX_SRC_BASE >> 3));
    wire  [2:0]  src_num  = idx[2:0];
    wire         known    = src_hit | is_reg(idx);
    wire         sw_wr    = wr_low & (idx == `EDOU_IDX_SW_VAL);

    function automatic logic is_reg(input logic [7:0] a);
        is_reg = (a == `EDOU_IDX_EDGE_LO) || (a == `EDOU_IDX_EDGE_HI) || (a == `EDOU_IDX_XING_EN) ||
                 (a == `EDOU_IDX_ALERT_EN) || (a == `EDOU_IDX_ALERT_VAL) || (a == `EDOU_IDX_PIN_FUNC) ||
                 (a == `EDOU_IDX_DRIVE) || (a == `EDOU_IDX_SW_VAL) || (a == `EDOU_IDX_IN_STATE) ||
                 (a == `EDOU_IDX_OUT_STATE);
    endfunction

    // two-bit crossing code for channel n
    function automatic logic [1:0] code_of(input logic [2:0] n, input logic [7:0] lo, input logic [7:0] hi);
        logic [15:0] all;
        all = {hi, lo};
        code_of = all[{n, 1'b0} +: 2];
    endfunction

    // crossing edges and newly set alert flags
    wire  [7:0]  xing_rise = xing_s2 & ~xing_d;
    wire  [7:0]  xing_fall = ~xing_s2 & xing_d;
    wire  [7:0]  alert_new = alert_s2 & ~alert_d;

    // per-output update decision
    logic [7:0]  next_level;
    logic [7:0]  alert_hit;
    logic [7:0]  xing_hit;
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            logic [1:0] code;
            code = code_of(3'(n), edge_code_lo, edge_code_hi);
            alert_hit[n] = alert_en[n] & |(alert_new & src_sel[n]);
            xing_hit[n]  = xing_en[n] & (xing_rise[n] | xing_fall[n]);
            next_level[n] = out_level[n];
            if (sw_wr) begin
                next_level[n] = i_avs_writedata[n];
            end
            if (xing_hit[n]) begin
                next_level[n] = xing_rise[n] ? code[1] : code[0];
            end
            if (alert_hit[n]) begin
                next_level[n] = alert_val[n];
            end
        end
    end

    // synchroniser and edge history
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pad_s1   <= 8'h00;
            pad_s2   <= 8'h00;
            xing_s1  <= 8'h00;
            xing_s2  <= 8'h00;
            xing_d   <= 8'h00;
            alert_s1 <= 8'h00;
            alert_s2 <= 8'h00;
            alert_d  <= 8'h00;
        end else begin
            pad_s1   <= i_pad_in;
            pad_s2   <= pad_s1;
            xing_s1  <= i_xing;
            xing_s2  <= xing_s1;
            xing_d   <= xing_s2;
            alert_s1 <= i_alert_flags;
            alert_s2 <= alert_s1;
            alert_d  <= alert_s2;
        end
    end

    // output level and input readback; output pins read as zero
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            out_level <= `EDOU_RST_BYTE;
            in_state  <= `EDOU_RST_BYTE;
        end else begin
            out_level <= next_level;
            in_state  <= pad_s2 & ~pin_func;
        end
    end

    // register writes, low byte lane only
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            edge_code_lo <= `EDOU_RST_BYTE;
            edge_code_hi <= `EDOU_RST_BYTE;
            xing_en      <= `EDOU_RST_BYTE;
            alert_en     <= `EDOU_RST_BYTE;
            alert_val    <= `EDOU_RST_BYTE;
            pin_func     <= `EDOU_RST_BYTE;
            drive_pp     <= `EDOU_RST_BYTE;
            sw_val       <= `EDOU_RST_BYTE;
            for (int n = 0; n < 8; n++) begin
                src_sel[n] <= `EDOU_RST_BYTE;
            end
        end else if (wr_low) begin
            case (idx)
                `EDOU_IDX_EDGE_LO:   edge_code_lo <= i_avs_writedata[7:0];
                `EDOU_IDX_EDGE_HI:   edge_code_hi <= i_avs_writedata[7:0];
                `EDOU_IDX_XING_EN:   xing_en      <= i_avs_writedata[7:0];
                `EDOU_IDX_ALERT_EN:  alert_en     <= i_avs_writedata[7:0];
                `EDOU_IDX_ALERT_VAL: alert_val    <= i_avs_writedata[7:0];
                `EDOU_IDX_PIN_FUNC:  pin_func     <= i_avs_writedata[7:0];
                `EDOU_IDX_DRIVE:     drive_pp     <= i_avs_writedata[7:0];
                `EDOU_IDX_SW_VAL:    sw_val       <= i_avs_writedata[7:0];
                default: begin
                    if (src_hit) begin
                        src_sel[src_num] <= i_avs_writedata[7:0];
                    end
                end
            endcase
        end
    end

    // read mux
    logic [7:0] rd_byte;
    always_comb begin
        case (idx)
            `EDOU_IDX_EDGE_LO:   rd_byte = edge_code_lo;
            `EDOU_IDX_EDGE_HI:   rd_byte = edge_code_hi;
            `EDOU_IDX_XING_EN:   rd_byte = xing_en;
            `EDOU_IDX_ALERT_EN:  rd_byte = alert_en;
            `EDOU_IDX_ALERT_VAL: rd_byte = alert_val;
            `EDOU_IDX_PIN_FUNC:  rd_byte = pin_func;
            `EDOU_IDX_DRIVE:     rd_byte = drive_pp;
            `EDOU_IDX_SW_VAL:    rd_byte = sw_val;
            `EDOU_IDX_IN_STATE:  rd_byte = in_state;
            `EDOU_IDX_OUT_STATE: rd_byte = out_level;
            default:             rd_byte = src_hit ? src_sel[src_num] : 8'h00;
        endcase
    end

    // one wait cycle per access so read data comes from a flip-flop
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            bus_state      <= edou_pkg::EDOU_BUS_IDLE;
            o_avs_readdata <= 32'h0000_0000;
            o_avs_response <= 2'h0;
        end else begin
            case (bus_state)
                edou_pkg::EDOU_BUS_IDLE: begin
                    if (req) begin
                        bus_state      <= edou_pkg::EDOU_BUS_ANSWER;
                        o_avs_readdata <= {24'h00_0000, (known & aligned) ? rd_byte : 8'h00};
                        o_avs_response <= (known & aligned) ? 2'h0 : 2'h3;
                    end
                end
                edou_pkg::EDOU_BUS_ANSWER: bus_state <= edou_pkg::EDOU_BUS_IDLE;
                default:                   bus_state <= edou_pkg::EDOU_BUS_IDLE;
            endcase
        end
    end
    assign o_avs_waitrequest = ~(bus_state == edou_pkg::EDOU_BUS_ANSWER);

    // pin mode: function bit one means output, drive bit one means push-pull
    assign pin_bus.level        = out_level;
    assign pin_bus.is_output    = pin_func;
    assign pin_bus.is_push_pull = drive_pp & pin_func;

    edou_pad u_pad (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .pin        (pin_bus.pad),
        .o_pad_out  (o_pad_out),
        .o_pad_oe_n (o_pad_oe_n)
    );

    // a crossing with its enable clear never moves the output
    xing_off_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (!xing_en[0] && !alert_en[0] && !sw_wr && (xing_rise[0] || xing_fall[0])) |=> $stable(out_level[0]))
        else $error("disabled crossing changed output");
    xing_code_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (xing_en[0] && !alert_hit[0] && xing_rise[0]) |=> out_level[0] == $past(edge_code_lo[1]))
        else $error("rising crossing level wrong");
    xing_fall_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (xing_en[0] && !alert_hit[0] && xing_fall[0]) |=> out_level[0] == $past(edge_code_lo[0]))
        else $error("falling crossing level wrong");
    alert_load_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (alert_en[1] && |(alert_new & src_sel[1])) |=> out_level[1] == $past(alert_val[1]))
        else $error("alert load wrong");
    alert_off_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (!alert_en[1] && !xing_en[1] && !sw_wr) |=> $stable(out_level[1]))
        else $error("disabled alert changed output");
    src_mask_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (src_sel[2] == 8'h00 && !xing_en[2] && !sw_wr) |=> $stable(out_level[2]))
        else $error("unselected alert changed output");
    sw_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        (sw_wr && !xing_hit[3] && !alert_hit[3]) |=> out_level[3] == $past(i_avs_writedata[3]))
        else $error("software write not applied");
    in_read_a: assert property (@(posedge i_clk) disable iff (i_srst)
        !pin_func[4] ##1 !pin_func[4] |-> in_state[4] == $past(pad_s2[4]))
        else $error("input state wrong");
endmodule

// *** testbench/edou_ext_pins.sv ***
// outside circuits on the eight pins: pull-ups and optional drivers
`timescale 1ns/100ps
module edou_ext_pins (
    input  wire logic [7:0] i_pad_out,
    input  wire logic [7:0] i_pad_oe_n,
    input  wire logic [7:0] i_ext_val,
    input  wire logic [7:0] i_ext_en,
    output logic      [7:0] o_line
);
    // a released pin sits at the pull-up unless an outside driver holds it
    // while pin modes change the bench also drives pins the block drives; there the pad simply wins
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (!i_pad_oe_n[b]) begin
                o_line[b] = i_pad_out[b];
            end else if (i_ext_en[b]) begin
                o_line[b] = i_ext_val[b];
            end else begin
                o_line[b] = 1'b1;
            end
        end
    end
endmodule

// *** testbench/edou_top_tb_top.sv ***
// self-checking bench for the event driven output block
`timescale 1ns/100ps
`include "edou_params.svh"
module edou_top_tb_top;
    logic        i_clk;
    logic        i_srst;
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic [7:0]  xing;
    logic [7:0]  alert_flags;
    logic [7:0]  pad_out;
    logic [7:0]  pad_oe_n;
    logic [7:0]  line;
    logic [7:0]  ext_val;
    logic [7:0]  ext_en;
    logic [31:0] lfsr;
    logic [31:0] rd;
    logic [1:0]  rsp;
    logic [7:0]  sw;
    logic [7:0]  en;
    logic [7:0]  val;
    logic [7:0]  r;
    logic [7:0]  ex;
    logic [7:0]  src [8];
    logic [7:0]  reg_idx [5] = '{`EDOU_IDX_EDGE_LO, `EDOU_IDX_EDGE_HI, `EDOU_IDX_XING_EN,
                                 `EDOU_IDX_ALERT_EN, `EDOU_IDX_ALERT_VAL};
    int          errors;
    int          checked;

    edou_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_avs_address(avs_address), .i_avs_read(avs_read),
        .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .o_avs_response(avs_response),
        .i_xing(xing), .i_alert_flags(alert_flags), .i_pad_in(line), .o_pad_out(pad_out), .o_pad_oe_n(pad_oe_n));
    edou_ext_pins ext (.i_pad_out(pad_out), .i_pad_oe_n(pad_oe_n), .i_ext_val(ext_val), .i_ext_en(ext_en),
        .o_line(line));

    // free-running 250 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // random bytes from a shift register, eight steps apart to break up correlation
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic get_rand(output logic [7:0] v);
        repeat (8) lfsr = next_rand(lfsr);
        v = lfsr[7:0];
    endtask

    // level after one crossing edge, enabled outputs only
    function automatic logic [7:0] exp_xing(input logic [7:0] p, input logic [7:0] e, input logic [1:0] c,
                                            input logic rising);
        exp_xing = (p & ~e) | (e & {8{rising ? c[1] : c[0]}});
    endfunction
    // level after the flags in rise go high, per-output source masks in s
    function automatic logic [7:0] exp_alert(input logic [7:0] p, input logic [7:0] e, input logic [7:0] v,
                                             input logic [7:0] rise, input logic [7:0] s [8]);
        for (int n = 0; n < 8; n++) begin
            if (e[n] && (rise & s[n]) != 8'h00) begin
                p[n] = v[n];
            end
        end
        exp_alert = p;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one bus access; request held until the edge that sees waitrequest low, data taken there
    // values read just after an edge are the ones the slave showed at it; only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge i_clk);
        avs_address   <= {idx, 2'b00};
        avs_read      <= ~wr;
        avs_write     <= wr;
        avs_writedata <= {24'h000000, wd};
        do begin
            @(posedge i_clk);
        end while (avs_waitrequest !== 1'b0);
        rd  = avs_readdata;
        rsp = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
        bus(1'b0, idx, 8'h00);
        check(rd, {24'h000000, exp});
        check({30'h0, rsp}, {30'h0, er});
    endtask
    // synchroniser plus output register latency, with margin
    task automatic settle();
        repeat (6) @(posedge i_clk);
    endtask

    task automatic test_done();
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        #100000;
        errors++;
        test_done();
    end

    initial begin
        i_srst = 1'b1; avs_address = 10'h000; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = 32'h00000000; avs_byteenable = 4'hf; xing = 8'h00; alert_flags = 8'h00;
        ext_val = 8'h00; ext_en = 8'h00; lfsr = 32'h668f; errors = 0; checked = 0;
        repeat (4) @(posedge i_clk);
        i_srst <= 1'b0;
        // reset contents, released pads, unmapped index
        foreach (reg_idx[i]) rdchk(reg_idx[i], 8'h00, 2'h0);
        check({24'h0, pad_oe_n}, 32'h000000ff);
        rdchk(8'hff, 8'h00, 2'h3);
        // read back random contents; a write without lane 0 must not land
        foreach (reg_idx[i]) begin
            get_rand(val);
            wr(reg_idx[i], val);
            rdchk(reg_idx[i], val, 2'h0);
        end
        avs_byteenable <= 4'he;
        wr(reg_idx[4], ~val);
        avs_byteenable <= 4'hf;
        rdchk(reg_idx[4], val, 2'h0);
        foreach (reg_idx[i]) wr(reg_idx[i], 8'h00);
        // all outputs, random push-pull mask: open-drain ones release where high
        get_rand(r);
        get_rand(sw);
        wr(`EDOU_IDX_PIN_FUNC, 8'hff);
        wr(`EDOU_IDX_DRIVE, r);
        wr(`EDOU_IDX_SW_VAL, sw);
        settle();
        check({24'h0, line}, {24'h0, sw});
        check({24'h0, pad_oe_n & r}, 32'h0);
        check({24'h0, pad_oe_n & ~r}, {24'h0, sw & ~r});
        rdchk(`EDOU_IDX_OUT_STATE, sw, 2'h0);
        // random input pins held by outside drivers
        get_rand(en);
        get_rand(val);
        ext_val <= val;
        ext_en  <= ~en;
        wr(`EDOU_IDX_PIN_FUNC, en);
        settle();
        rdchk(`EDOU_IDX_IN_STATE, val & ~en, 2'h0);
        check({24'h0, pad_oe_n & ~en}, {24'h0, ~en});
        wr(`EDOU_IDX_PIN_FUNC, 8'hff);
        wr(`EDOU_IDX_DRIVE, 8'hff);
        ext_en <= 8'h00;
        // with both enables clear, events leave the software value alone
        xing        <= 8'hff;
        alert_flags <= 8'hff;
        settle();
        xing        <= 8'h00;
        alert_flags <= 8'h00;
        settle();
        check({24'h0, pad_out}, {24'h0, sw});
        // every edge code on a random set of crossing-enabled outputs
        for (int c = 0; c < 4; c++) begin
            get_rand(en);
            get_rand(sw);
            wr(`EDOU_IDX_SW_VAL, sw);
            wr(`EDOU_IDX_EDGE_LO, {4{c[1:0]}});
            wr(`EDOU_IDX_EDGE_HI, {4{c[1:0]}});
            wr(`EDOU_IDX_XING_EN, en);
            xing <= 8'hff;
            settle();
            ex = exp_xing(sw, en, c[1:0], 1'b1);
            check({24'h0, pad_out}, {24'h0, ex});
            xing <= 8'h00;
            settle();
            check({24'h0, pad_out}, {24'h0, exp_xing(ex, en, c[1:0], 1'b0)});
        end
        wr(`EDOU_IDX_XING_EN, 8'h00);
        // random alert enables, values and source masks; the falling flags must change nothing
        for (int k = 0; k < 4; k++) begin
            get_rand(en);
            get_rand(val);
            get_rand(r);
            get_rand(sw);
            for (int n = 0; n < 8; n++) begin
                get_rand(src[n]);
                wr(8'(`EDOU_IDX_SRC_BASE + n), src[n]);
            end
            wr(`EDOU_IDX_SW_VAL, sw);
            wr(`EDOU_IDX_ALERT_EN, en);
            wr(`EDOU_IDX_ALERT_VAL, val);
            alert_flags <= r;
            settle();
            ex = exp_alert(sw, en, val, r, src);
            check({24'h0, pad_out}, {24'h0, ex});
            alert_flags <= 8'h00;
            settle();
            check({24'h0, pad_out}, {24'h0, ex});
        end
        test_done();
    end
endmodule
